// *** include/csf_pkg.sv ***
// How it works
// - A flag-updating instruction aimed here drops its data write to zero and both carries; flag logic sets zero, and the carries only on add or subtract.
// - Data writes never change the watchdog expired flag or the power-down flag.
// - The register zero instruction aimed here clears the bank bits, sets zero and keeps the reset and carry flags.
// - In subtraction carry and nibble carry read one when no borrow occurred.
// - Bit 7 picks banks 2 and 3 (100h-1FFh) when one, banks 0 and 1 when zero, for indirect access.
// - Bits 6-5 pick the direct bank: 00 bank 0 (00h-7Fh) up to 11 bank 3 (180h-1FFh).
// - Bit 4 is one after power-up, watchdog clear or low-power entry, and zero after a watchdog time-out.
// - Bit 3 is one after power-up or watchdog clear, and zero after the low-power instruction.
// - Bit 2 is one when an arithmetic or logic result is zero, else zero.
// - For add and subtract, bit 1 is the carry out of the low nibble of the result.
// - For add and subtract, bit 0 is the carry out of the most significant result bit.
`default_nettype none
package csf_pkg;
	localparam int unsigned APB_AW = 8;
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_RESULT = 8'h04;
	localparam int unsigned BIT_IND_BANK = 7;
	localparam int unsigned BIT_DIR_BANK_HI = 6;
	localparam int unsigned BIT_DIR_BANK_LO = 5;
	localparam int unsigned BIT_WDT_EXPIRED = 4;
	localparam int unsigned BIT_PWR_DOWN = 3;
	localparam int unsigned BIT_Z = 2;
	localparam int unsigned BIT_NIB_CARRY = 1;
	localparam int unsigned BIT_C = 0;
	localparam logic [7:0] STATUS_RST = 8'h18;
	// Bits a plain data write may change
	localparam logic [7:0] MASK_SW = 8'he7;
	localparam logic [7:0] MASK_BANK = 8'he0;
	localparam logic [8:0] IND_BASE_HI = 9'h100;
	localparam logic [8:0] IND_BASE_LO = 9'h000;
	localparam logic [6:0] DIR_BASE_LOW = 7'h00;
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_MOVE = 3'b001,
		OP_ADD = 3'b010,
		OP_SUB = 3'b011,
		OP_LOGIC = 3'b100,
		OP_CLR = 3'b101,
		OP_WDCLR = 3'b110,
		OP_SLEEP = 3'b111
	} csf_op_t;
endpackage : csf_pkg
`default_nettype wire

// *** hw/csf_flag_calc.sv ***
`timescale 1ns/10ps
`default_nettype none
module csf_flag_calc #(
	parameter int unsigned WIDTH = 8
) (
	// Operands
	input wire logic [WIDTH-1:0] op_a,
	input wire logic [WIDTH-1:0] op_b,
	input wire logic subtract,
	// Result and carries
	output logic [WIDTH-1:0] sum,
	output logic carry,
	output logic nibble_carry
);
	generate
		if (WIDTH < 5) begin : g_bad_width
			$error("csf_flag_calc needs WIDTH of at least 5");
		end
	endgenerate

	// Subtract as a plus inverted b plus one, so carry out means no borrow
	logic [WIDTH-1:0] b_eff;
	logic [WIDTH:0] full;
	logic [4:0] low;
	assign b_eff = subtract ? ~op_b : op_b;
	assign full = {1'b0, op_a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, subtract};
	assign low = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, subtract};
	assign sum = full[WIDTH-1:0];
	assign carry = full[WIDTH];
	assign nibble_carry = low[4];
endmodule : csf_flag_calc
`default_nettype wire

// *** hw/csf_sync3.sv ***
`timescale 1ns/10ps
`default_nettype none
module csf_sync3 (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Async level in, clean rise out
	input wire logic din,
	output logic rise
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic lvl_r;
	logic rise_r;
	logic agree;
	assign agree = (s2_r == s3_r);
	assign rise = rise_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			lvl_r <= 1'b0;
			rise_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// A change counts only once stages two and three agree
			if (agree) begin
				lvl_r <= s2_r;
			end
			rise_r <= agree & s2_r & ~lvl_r;
		end
	end
endmodule : csf_sync3
`default_nettype wire

// *** hw/csf_status_reg.sv ***
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module csf_status_reg (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [csf_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Execution datapath
	input wire logic exec_valid,
	input wire csf_pkg::csf_op_t exec_op,
	input wire logic exec_dest_status,
	input wire logic [7:0] exec_a,
	input wire logic [7:0] exec_b,
	output logic [7:0] alu_result,
	// Watchdog time-out, asynchronous level
	input wire logic wdt_timeout_pin,
	// Register and bank selects toward memory decode
	output logic [7:0] cpu_status_flags,
	output logic indirect_bank_select,
	output logic [1:0] direct_bank_select,
	output logic [8:0] indirect_bank_base,
	output logic [8:0] direct_bank_base
);
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic [7:0] alu_result_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [8:0] ind_base_r;
	logic [8:0] dir_base_r;

	// APB decode; every access takes one wait state
	logic apb_access;
	logic apb_start;
	logic apb_done;
	logic hit_status;
	logic hit_result;
	logic addr_hit;
	logic sw_write;
	logic [7:0] rd_mux;
	assign apb_access = psel & penable;
	assign apb_start = apb_access & ~pready_r;
	assign apb_done = apb_access & pready_r;
	assign hit_status = (paddr == csf_pkg::OFF_STATUS);
	assign hit_result = (paddr == csf_pkg::OFF_RESULT);
	assign addr_hit = hit_status | hit_result;
	assign sw_write = apb_done & pwrite & pstrb[0] & hit_status;
	assign rd_mux = hit_status ? status_r : (hit_result ? alu_result_r : 8'h00);

	// Instruction decode
	logic is_move;
	logic is_add;
	logic is_sub;
	logic is_logic;
	logic is_clr;
	logic is_wdclr;
	logic is_sleep;
	logic is_arith;
	logic flag_z_op;
	logic to_dest;
	assign is_move = exec_valid & (exec_op == csf_pkg::OP_MOVE);
	assign is_add = exec_valid & (exec_op == csf_pkg::OP_ADD);
	assign is_sub = exec_valid & (exec_op == csf_pkg::OP_SUB);
	assign is_logic = exec_valid & (exec_op == csf_pkg::OP_LOGIC);
	assign is_clr = exec_valid & (exec_op == csf_pkg::OP_CLR);
	assign is_wdclr = exec_valid & (exec_op == csf_pkg::OP_WDCLR);
	assign is_sleep = exec_valid & (exec_op == csf_pkg::OP_SLEEP);
	assign is_arith = is_add | is_sub;
	assign flag_z_op = is_arith | is_logic | is_clr;
	assign to_dest = exec_valid & exec_dest_status;

	// Flag logic
	logic [7:0] arith_sum;
	logic arith_c;
	logic arith_nib;
	logic [7:0] op_result;
	logic res_zero;
	logic [2:0] arith_flags;
	csf_flag_calc #(
		.WIDTH(8)
	) u_flag_calc (
		.op_a(exec_a),
		.op_b(exec_b),
		.subtract(is_sub),
		.sum(arith_sum),
		.carry(arith_c),
		.nibble_carry(arith_nib)
	);
	assign op_result = is_arith ? arith_sum : (is_clr ? 8'h00 : exec_a);
	assign res_zero = (op_result == 8'h00);
	assign arith_flags = {res_zero, arith_nib, arith_c};

	// Watchdog event from the pin
	logic wdt_evt;
	csf_sync3 u_wdt_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din(wdt_timeout_pin),
		.rise(wdt_evt)
	);

	// Later steps override earlier ones: bus write, then instruction, then time-out
	always_comb begin
		status_nxt = status_r;
		if (sw_write) begin
			status_nxt = (status_r & ~csf_pkg::MASK_SW) | (pwdata[7:0] & csf_pkg::MASK_SW);
		end
		if (to_dest & (is_move | flag_z_op)) begin
			if (is_move) begin
				status_nxt = (status_nxt & ~csf_pkg::MASK_SW) | (exec_a & csf_pkg::MASK_SW);
			end else begin
				// Only the bank bits take the data; zero and the add or subtract carries come from flag logic, the rest holds
				status_nxt = (status_nxt & ~csf_pkg::MASK_BANK) | (op_result & csf_pkg::MASK_BANK);
			end
		end
		if (flag_z_op) begin
			status_nxt[csf_pkg::BIT_Z] = res_zero;
		end
		if (is_arith) begin
			status_nxt[csf_pkg::BIT_NIB_CARRY] = arith_nib;
			status_nxt[csf_pkg::BIT_C] = arith_c;
		end
		if (is_wdclr) begin
			status_nxt[csf_pkg::BIT_WDT_EXPIRED] = 1'b1;
			status_nxt[csf_pkg::BIT_PWR_DOWN] = 1'b1;
		end
		if (is_sleep) begin
			status_nxt[csf_pkg::BIT_WDT_EXPIRED] = 1'b1;
			status_nxt[csf_pkg::BIT_PWR_DOWN] = 1'b0;
		end
		if (wdt_evt) begin
			status_nxt[csf_pkg::BIT_WDT_EXPIRED] = 1'b0;
		end
	end

	// Bank bases follow the register so decode never lags it
	logic [8:0] ind_base_nxt;
	logic [8:0] dir_base_nxt;
	assign ind_base_nxt = status_nxt[csf_pkg::BIT_IND_BANK] ? csf_pkg::IND_BASE_HI : csf_pkg::IND_BASE_LO;
	assign dir_base_nxt = {status_nxt[csf_pkg::BIT_DIR_BANK_HI:csf_pkg::BIT_DIR_BANK_LO], csf_pkg::DIR_BASE_LOW};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= csf_pkg::STATUS_RST;
			ind_base_r <= csf_pkg::IND_BASE_LO;
			dir_base_r <= 9'h000;
		end else begin
			status_r <= status_nxt;
			ind_base_r <= ind_base_nxt;
			dir_base_r <= dir_base_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alu_result_r <= 8'h00;
		end else if (is_move | flag_z_op) begin
			alu_result_r <= op_result;
		end
	end

	// Read data is latched at the first access cycle and held for the ready cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= apb_start;
			pslverr_r <= apb_start & ~addr_hit;
			if (apb_start) begin
				prdata_r <= {24'h00_0000, rd_mux};
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign alu_result = alu_result_r;
	assign cpu_status_flags = status_r;
	assign indirect_bank_select = status_r[csf_pkg::BIT_IND_BANK];
	assign direct_bank_select = status_r[csf_pkg::BIT_DIR_BANK_HI:csf_pkg::BIT_DIR_BANK_LO];
	assign indirect_bank_base = ind_base_r;
	assign direct_bank_base = dir_base_r;

	// Checks
	logic [4:0] nib_chk;
	logic [7:0] move_chk;
	assign nib_chk = {1'b0, exec_a[3:0]} + {1'b0, exec_b[3:0]};
	assign move_chk = (status_r & ~csf_pkg::MASK_SW) | (exec_a & csf_pkg::MASK_SW);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_sleep;
		is_sleep && !wdt_evt;
	endsequence
	sequence s_wdclr;
		is_wdclr && !wdt_evt;
	endsequence
	sequence s_no_reset_evt;
		!wdt_evt && !is_wdclr && !is_sleep;
	endsequence

	a_flag_write_block: assert property (
		(to_dest && is_arith) |=> (status_r[2:0] == $past(arith_flags)))
		else $error("flag bits took data instead of flag logic");
	a_ro_flags_hold: assert property (
		s_no_reset_evt |=> $stable(status_r[4:3]))
		else $error("reset flags changed without a hardware event");
	a_clr_effect: assert property (
		(is_clr && to_dest) |=> (status_r[7:5] == 3'b000) && status_r[2]
			&& (status_r[1:0] == $past(status_r[1:0])))
		else $error("register zero gave wrong result");
	a_sub_borrow: assert property (
		is_sub |=> (status_r[0] == ($past(exec_a) >= $past(exec_b))))
		else $error("subtract carry is not inverted borrow");
	a_ind_bank: assert property (
		indirect_bank_base == (status_r[7] ? 9'h100 : 9'h000))
		else $error("indirect bank base wrong");
	a_dir_bank: assert property (
		direct_bank_base == {status_r[6:5], 7'h00})
		else $error("direct bank base wrong");
	a_timeout_clear: assert property (
		wdt_evt |=> !status_r[4] ##1 (!status_r[4] || $past(is_wdclr || is_sleep)))
		else $error("time-out did not clear expired flag");
	a_sleep_flags: assert property (
		s_sleep |=> status_r[4] && !status_r[3])
		else $error("low-power entry gave wrong reset flags");
	a_wdclr_flags: assert property (
		s_wdclr |=> status_r[4] && status_r[3])
		else $error("watchdog clear gave wrong reset flags");
	a_zero_logic: assert property (
		is_logic |=> (status_r[2] == ($past(exec_a) == 8'h00)))
		else $error("zero flag wrong after logic result");
	a_add_nibble: assert property (
		is_add |=> (status_r[1] == $past(nib_chk[4])))
		else $error("nibble carry wrong after add");
	a_add_carry: assert property (
		is_add |=> (status_r[0] == ($past({1'b0, exec_a} + {1'b0, exec_b}) > 9'h0ff)))
		else $error("carry wrong after add");
	a_move_write: assert property (
		(is_move && to_dest && !wdt_evt) |=> (status_r == $past(move_chk)))
		else $error("plain write stored wrong value");
	a_apb_wait: assert property (
		apb_start |=> pready ##1 !pready)
		else $error("bus answer not one wait state");

	// Bus side steps and lone register events
	sequence s_status_read;
		apb_start && !pwrite && (paddr == csf_pkg::OFF_STATUS);
	endsequence
	sequence s_unmapped;
		apb_start && (paddr != csf_pkg::OFF_STATUS) && (paddr != csf_pkg::OFF_RESULT);
	endsequence
	sequence s_plain_write;
		sw_write && !exec_valid && !wdt_evt;
	endsequence
	sequence s_logic_here;
		is_logic && to_dest && !sw_write && !wdt_evt;
	endsequence

	a_sub_nibble: assert property (
		is_sub |=> (status_r[1] == ($past(exec_a[3:0]) >= $past(exec_b[3:0]))))
		else $error("subtract nibble carry is not inverted borrow");
	a_sub_zero: assert property (
		is_sub |=> (status_r[2] == ($past(exec_a) == $past(exec_b))))
		else $error("zero flag wrong after subtract");
	a_add_zero: assert property (
		is_add |=> (status_r[2] == (($past(exec_a) + $past(exec_b)) == 8'h00)))
		else $error("zero flag wrong after add");
	a_logic_dest: assert property (
		s_logic_here |=> (status_r[1:0] == $past(status_r[1:0])) && (status_r[7:5] == $past(exec_a[7:5])))
		else $error("logic result reached carry bits");
	a_plain_write: assert property (
		s_plain_write |=> (status_r == (($past(status_r) & 8'h18) | ($past(pwdata[7:0]) & 8'he7))))
		else $error("bus write reached reset flags");
	a_clr_result: assert property (
		is_clr |=> (alu_result == 8'h00))
		else $error("register zero left a nonzero result");
	a_move_result: assert property (
		is_move |=> (alu_result == $past(exec_a)))
		else $error("plain write result not kept");
	a_status_read: assert property (
		s_status_read |=> (prdata == {24'h00_0000, $past(status_r)}))
		else $error("read data differs from register");
	a_unmapped_err: assert property (
		s_unmapped |=> pslverr && (prdata == 32'h0000_0000))
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (
		(apb_start && ((paddr == csf_pkg::OFF_STATUS) || (paddr == csf_pkg::OFF_RESULT))) |=> !pslverr)
		else $error("mapped access flagged as error");
endmodule : csf_status_reg
`default_nettype wire

// *** verif/csf_exec_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module csf_exec_model (
	// Clock
	input wire logic pclk,
	// Instruction issue toward the status register
	output logic exec_valid,
	output var csf_pkg::csf_op_t exec_op,
	output logic exec_dest_status,
	output logic [7:0] exec_a,
	output logic [7:0] exec_b
);
	initial begin
		exec_valid = 1'b0;
		exec_op = csf_pkg::OP_NONE;
		exec_dest_status = 1'b0;
		exec_a = 8'h00;
		exec_b = 8'h00;
	end

	// One pulse per instruction; operands are scrambled afterwards so stale data is never taken as live
	task issue(input csf_pkg::csf_op_t op, input logic dst, input logic [7:0] a, input logic [7:0] b);
		@(posedge pclk);
		exec_valid <= 1'b1;
		exec_op <= op;
		exec_dest_status <= dst;
		exec_a <= a;
		exec_b <= b;
		@(posedge pclk);
		exec_valid <= 1'b0;
		exec_dest_status <= ~dst;
		exec_a <= ~a;
		exec_b <= ~b;
	endtask : issue
endmodule : csf_exec_model
`default_nettype wire

// *** verif/test_csf_status_reg.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_csf_status_reg;
	typedef struct packed {logic [31:0] d; logic e; logic rd;} csf_exp_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic wdt_pin = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready, pslverr, ev, ed, ibs;
	csf_pkg::csf_op_t eo;
	logic [7:0] ea, eb, res_o, flags, st, res;
	logic [1:0] dbs;
	logic [8:0] ibase, dbase;
	int err_count = 0;
	int check_count = 0;
	integer seed = 32'he368_0595;
	integer v;
	csf_exp_t q[$];
	csf_exp_t m;

	always #4 pclk = ~pclk;

	csf_status_reg u_csf_status_reg (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .exec_valid(ev), .exec_op(eo), .exec_dest_status(ed),
		.exec_a(ea), .exec_b(eb), .alu_result(res_o), .wdt_timeout_pin(wdt_pin),
		.cpu_status_flags(flags), .indirect_bank_select(ibs), .direct_bank_select(dbs),
		.indirect_bank_base(ibase), .direct_bank_base(dbase));

	csf_exec_model u_csf_exec_model (.pclk(pclk), .exec_valid(ev), .exec_op(eo),
		.exec_dest_status(ed), .exec_a(ea), .exec_b(eb));

	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, x, s);
		end
	endtask : chk

	task print_verdict;
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	// The expectation is queued before the setup cycle so the monitor always finds it
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [31:0] x, input logic e);
		int n;
		q.push_back('{x, e, !wr});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			chk("pready", 32'h0000_0000, 32'h0000_0001);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [7:0] a, input logic [31:0] x, input logic e);
		apb(1'b0, a, 32'h0000_0000, 4'hf, x, e);
	endtask : rd

	task run(input csf_pkg::csf_op_t op, input logic dst, input logic [7:0] a, input logic [7:0] b);
		logic [8:0] r;
		logic fl;
		r = 9'h000;
		fl = 1'b1;
		case (op)
			csf_pkg::OP_ADD: begin
				r = a + b;
				st[1] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
				st[0] = r[8];
			end
			csf_pkg::OP_SUB: begin
				r = {1'b0, a - b};
				// Borrow reads inverted: one means nothing was borrowed
				st[1] = a[3:0] >= b[3:0];
				st[0] = a >= b;
			end
			csf_pkg::OP_LOGIC: r = {1'b0, a};
			csf_pkg::OP_CLR: r = 9'h000;
			default: fl = 1'b0;
		endcase
		if (fl) begin
			st[2] = r[7:0] == 8'h00;
			if (dst)
				st[7:5] = r[7:5];
			res = r[7:0];
		end
		if (op == csf_pkg::OP_MOVE) begin
			res = a;
			if (dst)
				st = {a[7:5], st[4:3], a[2:0]};
		end
		if (op == csf_pkg::OP_WDCLR)
			st[4:3] = 2'b11;
		if (op == csf_pkg::OP_SLEEP)
			st[4:3] = 2'b10;
		u_csf_exec_model.issue(op, dst, a, b);
		rd(8'h00, {24'h00_0000, st}, 1'b0);
		rd(8'h04, {24'h00_0000, res}, 1'b0);
		chk("flags", {24'h00_0000, flags}, {24'h00_0000, st});
		chk("alu_result", {24'h00_0000, res_o}, {24'h00_0000, res});
		chk("ibase", {23'h00_0000, ibase}, st[7] ? 32'h0000_0100 : 32'h0000_0000);
		chk("dbase", {23'h00_0000, dbase}, {23'h00_0000, st[6:5], 7'h00});
		chk("banksel", {29'h0000_0000, ibs, dbs}, {29'h0000_0000, st[7:5]});
	endtask : run

	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			m = q.pop_front();
			if (m.rd)
				chk("prdata", prdata, m.d);
			chk("pslverr", {31'h0000_0000, pslverr}, {31'h0000_0000, m.e});
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		print_verdict();
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		st = 8'h18;
		res = 8'h00;
		rd(8'h00, 32'h0000_0018, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0000, 4'h1, 32'h0000_0000, 1'b0);
		rd(8'h00, 32'h0000_0018, 1'b0);
		apb(1'b1, 8'h00, 32'hffff_ffff, 4'h0, 32'h0000_0000, 1'b0);
		rd(8'h00, 32'h0000_0018, 1'b0);
		apb(1'b1, 8'h00, 32'hffff_ffff, 4'h1, 32'h0000_0000, 1'b0);
		st = 8'hff;
		rd(8'h00, 32'h0000_00ff, 1'b0);
		apb(1'b1, 8'h04, 32'h0000_0055, 4'hf, 32'h0000_0000, 1'b0);
		rd(8'h04, 32'h0000_0000, 1'b0);
		rd(8'h08, 32'h0000_0000, 1'b1);
		apb(1'b1, 8'h08, 32'h0000_00aa, 4'hf, 32'h0000_0000, 1'b1);
		run(csf_pkg::OP_CLR, 1'b1, 8'h5a, 8'h00);
		run(csf_pkg::OP_ADD, 1'b1, 8'h0f, 8'h01);
		run(csf_pkg::OP_ADD, 1'b0, 8'hff, 8'h01);
		run(csf_pkg::OP_SUB, 1'b0, 8'h10, 8'h01);
		run(csf_pkg::OP_SUB, 1'b1, 8'he5, 8'he5);
		run(csf_pkg::OP_LOGIC, 1'b0, 8'h00, 8'h00);
		run(csf_pkg::OP_MOVE, 1'b1, 8'hff, 8'h00);
		run(csf_pkg::OP_SLEEP, 1'b0, 8'h00, 8'h00);
		wdt_pin <= 1'b1;
		repeat (10) @(posedge pclk);
		st[4] = 1'b0;
		rd(8'h00, {24'h00_0000, st}, 1'b0);
		wdt_pin <= 1'b0;
		run(csf_pkg::OP_WDCLR, 1'b0, 8'h00, 8'h00);
		repeat (80) begin
			v = $random(seed);
			run(csf_pkg::csf_op_t'(v[2:0]), v[3], v[15:8], v[23:16]);
		end
		print_verdict();
	end
endmodule : test_csf_status_reg
`default_nettype wire
